// File: logic/srt_adc_ctrl.sv
// Purpose: conversion sequencer and result readout of a 16-bit SAR converter
// Assumes: 40 MHz clk_sys; every pin but rst_b and cmp_keep passes a two-stage synchroniser first
// Notes: pin-to-pin times below one cycle cannot be met; see the timing limits
`timescale 1ns/1ps
module srt_adc_ctrl
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // conversion control
   input wire logic convert_strobe_n,
   output logic busy,
   // converter core
   output logic [srt_pkg::WORD_W-1:0] sar_trial,
   input wire logic cmp_keep,
   // interface configuration
   input wire logic interface_select,
   input wire logic slave_mode,
   input wire logic read_during_conv,
   input wire logic [1:0] serial_clock_divider,
   input wire logic cs_n,
   // parallel port
   output logic [srt_pkg::WORD_W-1:0] par_data_o,
   output logic par_data_oe,
   // serial port
   input wire logic host_sclk,
   input wire logic serial_chain_in,
   output logic serial_result_out,
   output logic serial_result_oe,
   output logic frame_sync_o,
   output logic serial_clk_o,
   output logic master_oe
);
   import srt_pkg::*;

   typedef struct packed {
      logic [SY_W-1:0] sy_m;
      logic [SY_W-1:0] sy_s;
      logic cnv_d;
      logic hck_d;
      srt_conv_t cst;
      logic [3:0] bitn;
      logic [WORD_W-1:0] sar;
      logic [3:0] tmr;
      logic busy;
      logic [4:0] scnt;
      srt_ser_t sst;
      logic [3:0] ph;
      logic [3:0] sbits;
      logic [WORD_W-1:0] sh;
      logic sdo;
      logic sync_o;
      logic sclk_o;
      logic ser_oe;
      logic mst_oe;
      logic [WORD_W-1:0] par;
      logic par_oe;
   } srt_ctrl_st_t;

   localparam srt_ctrl_st_t RST_ST = '{sy_m: SY_RST, sy_s: SY_RST, cnv_d: 1'b1,
      cst: C_IDLE, sst: S_IDLE, default: '0};
   localparam int DV_WIN = DATA_VALID_CYC - 3;

   srt_ctrl_st_t q;
   srt_ctrl_st_t next_q;
   logic ser;
   logic slv;
   logic dur;
   logic cs_act;
   logic cnv_fall;
   logic hck_fall;
   logic ser_end;
   logic go;
   logic [1:0] sel;
   logic [3:0] hi_n;
   logic [3:0] lo_n;
   logic [3:0] tr_n;
   logic buf_iv;
   logic buf_ir;
   logic buf_ov;
   logic buf_or;
   logic [WORD_W-1:0] buf_od;

   // decoded, already synchronised configuration
   assign ser = q.sy_s[SY_IFS];
   assign slv = q.sy_s[SY_SLV];
   assign dur = q.sy_s[SY_DUR];
   assign cs_act = ~q.sy_s[SY_CS];
   assign cnv_fall = q.cnv_d & ~q.sy_s[SY_CNV];
   assign hck_fall = q.hck_d & ~q.sy_s[SY_HCK];
   // read during conversion always runs at the fastest clock setting
   assign sel = dur ? 2'b00 : q.sy_s[SY_DIV +: 2];
   assign hi_n = 4'(hi_cyc(sel));
   assign lo_n = 4'(per_cyc(sel) - hi_cyc(sel));
   assign tr_n = 4'(trail_cyc(sel));
   assign ser_end = (q.sst == S_TRAIL) && (q.ph == 4'h0);
   assign go = ser & cs_act & buf_ov & (q.sst == S_IDLE) &
      (slv | ~dur | (q.scnt == 5'(FS_K)));
   assign buf_iv = q.cst == C_PUSH;
   // parallel readout drains at once; serial readout pops only on a new frame
   assign buf_or = ser ? go : 1'b1;

   srt_buf #(.W(WORD_W)) u_buf
   (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .in_valid(buf_iv),
      .in_ready(buf_ir),
      .in_data(q.sar),
      .out_valid(buf_ov),
      .out_ready(buf_or),
      .out_data(buf_od)
   );

   always_comb
   begin
      next_q = q;
      next_q.sy_m = {serial_chain_in, host_sclk, serial_clock_divider, read_during_conv,
         slave_mode, interface_select, cs_n, convert_strobe_n};
      next_q.sy_s = q.sy_m;
      next_q.cnv_d = q.sy_s[SY_CNV];
      next_q.hck_d = q.sy_s[SY_HCK];

      // conversion sequencer; strobes while busy are ignored
      case (q.cst)
         C_IDLE:
            if (cnv_fall)
            begin
               next_q.busy = 1'b1;
               next_q.sar = SAR_START;
               next_q.bitn = 4'hF;
               next_q.cst = C_CONV;
            end
         C_CONV:
         begin
            next_q.tmr = 4'h0;
            if (!cmp_keep)
               next_q.sar[q.bitn] = 1'b0;
            if (q.bitn == 4'h0)
               next_q.cst = C_PUSH;
            else
            begin
               next_q.sar[q.bitn - 4'h1] = 1'b1;
               next_q.bitn = q.bitn - 4'h1;
            end
         end
         C_PUSH:
         begin
            // a full buffer stalls the word here; busy still falls in time and new strobes are ignored until idle
            next_q.tmr = buf_ir ? 4'h0 : q.tmr + 4'h1;
            next_q.busy = q.busy & (buf_ir | (q.tmr != 4'(HOLD_CYC)));
            if (buf_ir)
               next_q.cst = (ser & ~slv & ~dur & q.busy) ? C_SERW : C_HOLD;
         end
         C_HOLD:
         begin
            next_q.tmr = q.tmr + 4'h1;
            if (q.tmr == 4'(HOLD_CYC))
            begin
               next_q.busy = 1'b0;
               next_q.cst = C_IDLE;
            end
         end
         C_SERW:
            if (ser_end || !ser || !cs_act)
               next_q.cst = C_DROP;
         C_DROP:
         begin
            next_q.busy = 1'b0;
            next_q.cst = C_IDLE;
         end
         default:
         begin
            next_q.busy = 1'b0;
            next_q.cst = C_IDLE;
         end
      endcase

      // strobe-to-marker delay for read during conversion
      if (cnv_fall && q.cst == C_IDLE)
         next_q.scnt = 5'h01;
      else if (q.scnt != 5'h00 && q.scnt != 5'(FS_K))
         next_q.scnt = q.scnt + 5'h01;
      else
         next_q.scnt = 5'h00;

      // parallel port
      next_q.par_oe = ~ser & cs_act;
      if (!ser && buf_ov)
         next_q.par = buf_od;

      // serial port; enables follow chip select
      next_q.ser_oe = ser & cs_act;
      next_q.mst_oe = ser & cs_act & ~slv;
      if (!ser || !cs_act)
      begin
         next_q.sst = S_IDLE;
         next_q.sync_o = 1'b0;
         next_q.sclk_o = 1'b0;
      end
      else
      begin
         case (q.sst)
            S_IDLE:
               if (go)
               begin
                  next_q.sh = buf_od;
                  next_q.sdo = buf_od[WORD_W-1];
                  next_q.sbits = 4'hF;
                  next_q.sync_o = ~slv;
                  next_q.ph = 4'(LEAD_CYC - 1);
                  next_q.sst = slv ? S_HI : S_LEAD;
               end
            S_LEAD:
               if (q.ph == 4'h0)
               begin
                  next_q.sclk_o = 1'b1;
                  next_q.ph = hi_n - 4'h1;
                  next_q.sst = S_HI;
               end
               else
                  next_q.ph = q.ph - 4'h1;
            S_HI:
               if (slv)
               begin
                  // slave keeps shifting chained data while selected
                  if (hck_fall)
                  begin
                     next_q.sh = {q.sh[WORD_W-2:0], q.sy_s[SY_CHN]};
                     next_q.sdo = q.sh[WORD_W-2];
                  end
               end
               else if (q.ph != 4'h0)
                  next_q.ph = q.ph - 4'h1;
               else
               begin
                  next_q.sclk_o = 1'b0;
                  if (q.sbits == 4'h0)
                  begin
                     next_q.ph = tr_n - 4'h1;
                     next_q.sst = S_TRAIL;
                  end
                  else
                  begin
                     next_q.sh = {q.sh[WORD_W-2:0], 1'b0};
                     next_q.sdo = q.sh[WORD_W-2];
                     next_q.sbits = q.sbits - 4'h1;
                     next_q.ph = lo_n - 4'h1;
                     next_q.sst = S_LO;
                  end
               end
            S_LO:
               if (q.ph == 4'h0)
               begin
                  next_q.sclk_o = 1'b1;
                  next_q.ph = hi_n - 4'h1;
                  next_q.sst = S_HI;
               end
               else
                  next_q.ph = q.ph - 4'h1;
            S_TRAIL:
               if (q.ph == 4'h0)
               begin
                  next_q.sync_o = 1'b0;
                  next_q.sst = S_IDLE;
               end
               else
                  next_q.ph = q.ph - 4'h1;
            default:
               next_q.sst = S_IDLE;
         endcase
      end
   end

   // reset aborts any conversion or frame
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         q <= RST_ST;
      else
         q <= next_q;
   end

   assign busy = q.busy;
   assign sar_trial = q.sar;
   assign par_data_o = q.par;
   assign par_data_oe = q.par_oe;
   assign serial_result_out = q.sdo;
   assign serial_result_oe = q.ser_oe;
   assign frame_sync_o = q.sync_o;
   assign serial_clk_o = q.sclk_o;
   assign master_oe = q.mst_oe;

   // helper counters read only by the checks below
   logic [7:0] bcnt;
   logic [3:0] hcnt;
   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
      begin
         bcnt <= 8'h00;
         hcnt <= 4'h0;
      end
      else
      begin
         bcnt <= !q.busy ? 8'h00 : ((bcnt == 8'hFF) ? bcnt : bcnt + 8'h01);
         hcnt <= q.sclk_o ? hcnt + 4'h1 : 4'h0;
      end
   end

   chk_busy_short: assert property (@(posedge clk_sys) disable iff (!rst_b)
      q.busy && !(ser && !slv && !dur) |-> bcnt < 8'(BUSY_MAX_CYC))
      else $error("busy high too long");
   chk_busy_after_eoc: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $fell(q.busy) |-> $past(q.cst, 1) != C_CONV && $past(q.cst, 2) != C_CONV)
      else $error("busy fell too soon after conversion");
   chk_par_valid_time: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(q.busy) && !ser |-> ##[1:DV_WIN] (q.cst == C_HOLD))
      else $error("parallel result late");
   chk_par_before_busy: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $fell(q.busy) && !ser |-> $past(q.cst, 4) == C_PUSH && $stable(q.par))
      else $error("result not settled before busy fell");
   chk_sync_during: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(q.sync_o) && dur |-> $past(q.scnt) == 5'(FS_K))
      else $error("frame marker off its strobe delay");
   chk_sclk_high: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $fell(q.sclk_o) && q.sync_o |-> hcnt == hi_n)
      else $error("serial clock high phase wrong");
   chk_ser_busy: assert property (@(posedge clk_sys) disable iff (!rst_b)
      q.busy && ser && !slv && !dur |-> bcnt < 8'(ser_busy_cyc(sel)))
      else $error("busy too long in read after conversion");
   chk_first_edge: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(q.sync_o) |-> !q.sclk_o ##1 (q.sclk_o || !q.sync_o))
      else $error("first serial clock edge misplaced");
   chk_trail_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $fell(q.sync_o) && cs_act && ser |-> !$past(q.sclk_o) && $past(q.sst) == S_TRAIL)
      else $error("frame marker dropped early");
   chk_busy_after_sync: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $fell(q.sync_o) && q.cst == C_DROP |=> $fell(q.busy))
      else $error("busy did not follow marker");
   chk_oe_cs: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !cs_act |=> !q.ser_oe && !q.mst_oe && !q.sync_o)
      else $error("serial outputs driven while deselected");
   chk_oe_master: assert property (@(posedge clk_sys) disable iff (!rst_b)
      cs_act && ser && !slv |=> q.mst_oe && q.ser_oe)
      else $error("master outputs not driven");
   chk_slave_shift: assert property (@(posedge clk_sys) disable iff (!rst_b)
      ser && cs_act && slv && hck_fall && q.sst == S_HI |=> q.sdo == $past(q.sh[WORD_W-2]))
      else $error("slave data did not advance");
endmodule // srt_adc_ctrl

// File: logic/srt_buf.sv
// Purpose: two-entry result buffer between converter and readout
// Assumes: single clock, valid/ready on both sides
// Notes: a full buffer holds in_ready low so the converter waits
`timescale 1ns/1ps
module srt_buf
#(
   parameter int W = 16
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   typedef struct packed {
      logic [1:0][W-1:0] mem;
      logic wp;
      logic rp;
      logic [1:0] cnt;
   } srt_buf_st_t;

   srt_buf_st_t q;
   srt_buf_st_t n;
   logic push;
   logic pop;

   assign in_ready = q.cnt != 2'h2;
   assign out_valid = q.cnt != 2'h0;
   assign out_data = q.mem[q.rp];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_comb
   begin
      n = q;
      if (push)
      begin
         n.mem[q.wp] = in_data;
         n.wp = ~q.wp;
      end
      if (pop)
         n.rp = ~q.rp;
      n.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clk_sys or negedge rst_b)
   begin
      if (!rst_b)
         q <= '0;
      else
         q <= n;
   end
endmodule // srt_buf

// File: logic/srt_pkg.sv
// Purpose: shared constants and types for the converter sequencer and readout
// Assumes: 40 MHz system clock, all times kept in ns and turned into cycles here
// Notes: least times round up, longest times round down, never below one cycle
package srt_pkg;
   localparam int CLK_NS = 25;

   function automatic int cyc_up(input int ns);
      return ((ns + CLK_NS - 1) / CLK_NS < 1) ? 1 : (ns + CLK_NS - 1) / CLK_NS;
   endfunction

   function automatic int cyc_dn(input int ns);
      return (ns / CLK_NS < 1) ? 1 : ns / CLK_NS;
   endfunction

   localparam int WORD_W = 16;
   localparam logic [15:0] SAR_START = 16'h8000;
   localparam int SYNC_LAT = 2;

   localparam int BUSY_MAX_NS = 1250;
   localparam int BUSY_MAX_CYC = cyc_dn(BUSY_MAX_NS);
   localparam int DATA_VALID_NS = 1250;
   localparam int DATA_VALID_CYC = cyc_dn(DATA_VALID_NS);
   localparam int EOC_BUSY_NS = 10;
   localparam int EOC_BUSY_CYC = cyc_up(EOC_BUSY_NS);
   localparam int DV_BUSY_NS = 45;
   localparam int DV_BUSY_CYC = cyc_up(DV_BUSY_NS);
   localparam int HOLD_CYC = (DV_BUSY_CYC > EOC_BUSY_CYC) ? DV_BUSY_CYC : EOC_BUSY_CYC;
   localparam int FS_DURING_NS = 525;
   localparam int FS_DURING_CYC = FS_DURING_NS / CLK_NS;
   localparam int FS_K = FS_DURING_CYC - SYNC_LAT;
   localparam int LEAD_NS = 17;
   localparam int LEAD_CYC = cyc_up(LEAD_NS);

   localparam int SCK_TYP_NS [4] = '{40, 70, 140, 280};
   localparam int SCK_MIN_NS [4] = '{25, 50, 100, 200};
   localparam int SCK_HI_NS [4] = '{12, 22, 50, 100};
   localparam int TRAIL_NS [4] = '{3, 60, 140, 300};
   localparam int SER_BUSY_NS [4] = '{2000, 2500, 3500, 5750};

   function automatic int hi_cyc(input logic [1:0] s);
      return cyc_up(SCK_HI_NS[s]);
   endfunction

   function automatic int per_cyc(input logic [1:0] s);
      return (cyc_up(SCK_TYP_NS[s]) > cyc_up(SCK_MIN_NS[s])) ? cyc_up(SCK_TYP_NS[s]) : cyc_up(SCK_MIN_NS[s]);
   endfunction

   function automatic int trail_cyc(input logic [1:0] s);
      return cyc_up(TRAIL_NS[s]);
   endfunction

   function automatic int ser_busy_cyc(input logic [1:0] s);
      return cyc_dn(SER_BUSY_NS[s]);
   endfunction

   // positions inside the pin synchroniser vector
   localparam int SY_CNV = 0;
   localparam int SY_CS = 1;
   localparam int SY_IFS = 2;
   localparam int SY_SLV = 3;
   localparam int SY_DUR = 4;
   localparam int SY_DIV = 5;
   localparam int SY_HCK = 7;
   localparam int SY_CHN = 8;
   localparam int SY_W = 9;
   localparam logic [8:0] SY_RST = 9'h003;

   typedef enum logic [2:0] {
      C_IDLE = 3'b000,
      C_CONV = 3'b001,
      C_PUSH = 3'b010,
      C_HOLD = 3'b011,
      C_SERW = 3'b100,
      C_DROP = 3'b101
   } srt_conv_t;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_LEAD = 3'b001,
      S_HI = 3'b010,
      S_LO = 3'b011,
      S_TRAIL = 3'b100
   } srt_ser_t;
endpackage

// File: testbench/srt_adc_ctrl_tb_top.sv
// Purpose: self-checking bench for the converter sequencer and readout
// Assumes: comparator modelled as trial <= input, so the result equals the input
// Notes: expected words kept in a queue, oldest first
`timescale 1ns/1ps
module srt_adc_ctrl_tb_top;
   import srt_pkg::*;
   logic clk_sys, rst_b, convert_strobe_n, cmp_keep, interface_select, slave_mode, read_during_conv, cs_n;
   logic host_sclk, serial_chain_in, busy, par_data_oe, serial_result_out, serial_result_oe;
   logic frame_sync_o, serial_clk_o, master_oe;
   logic [1:0] serial_clock_divider;
   logic [15:0] sar_trial, par_data_o, ain, w;
   logic [15:0] exp_q [$];
   int seed = 87;
   int num_errors = 0;
   int total_checks = 0;
   int bw, tfs, tdv, tbf, tsar, d, k;
   int typ_ns [4] = '{40, 70, 140, 280};
   int min_ns [4] = '{25, 50, 100, 200};
   int trl_ns [4] = '{3, 60, 140, 300};
   int bsy_ns [4] = '{2000, 2500, 3500, 5750};

   assign cmp_keep = (sar_trial <= ain);

   srt_adc_ctrl srt_adc_ctrl_i (.clk_sys(clk_sys), .rst_b(rst_b), .convert_strobe_n(convert_strobe_n),
      .busy(busy), .sar_trial(sar_trial), .cmp_keep(cmp_keep), .interface_select(interface_select),
      .slave_mode(slave_mode), .read_during_conv(read_during_conv), .serial_clock_divider(serial_clock_divider),
      .cs_n(cs_n), .par_data_o(par_data_o), .par_data_oe(par_data_oe), .host_sclk(host_sclk),
      .serial_chain_in(serial_chain_in), .serial_result_out(serial_result_out),
      .serial_result_oe(serial_result_oe), .frame_sync_o(frame_sync_o), .serial_clk_o(serial_clk_o),
      .master_oe(master_oe));

   srt_host_model srt_host_model_i (.clk_sys(clk_sys), .rst_b(rst_b), .busy(busy), .frame_sync_o(frame_sync_o),
      .serial_clk_o(serial_clk_o), .master_oe(master_oe), .serial_result_out(serial_result_out),
      .serial_result_oe(serial_result_oe), .host_sclk(host_sclk));

   initial
   begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic ok, input string m);
      total_checks++;
      if (ok !== 1'b1)
      begin
         num_errors++;
         $display("MISMATCH t=%0t %s", $time, m);
      end
   endtask

   // one conversion per 400 cycles keeps the strobe spacing at 10 us
   task automatic conv;
      int n;
      ain = 16'($random(seed));
      exp_q.push_back(ain);
      convert_strobe_n = 1'b0;
      bw = 0;
      tfs = -1;
      tdv = -1;
      tbf = -1;
      tsar = -1;
      for (n = 1; n <= 400; n++)
      begin
         @(posedge clk_sys) #2;
         if (n == 2)
            convert_strobe_n = 1'b1;
         serial_chain_in = 1'($random(seed));
         if (busy === 1'b1)
            bw++;
         if (busy === 1'b1)
            tbf = n + 1;
         if (tfs < 0 && frame_sync_o === 1'b1)
            tfs = n;
         if (tdv < 0 && par_data_o === ain)
            tdv = n;
         if (tsar < 0 && sar_trial === ain)
            tsar = n;
      end
   endtask

   // full run is about 5400 cycles; over five times that cuts a hang short
   initial
   begin
      repeat (30000) @(posedge clk_sys);
      num_errors++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      print_verdict;
   end

   initial
   begin
      rst_b = 1'b0;
      convert_strobe_n = 1'b1;
      cs_n = 1'b1;
      interface_select = 1'b0;
      slave_mode = 1'b0;
      read_during_conv = 1'b0;
      serial_clock_divider = 2'b00;
      serial_chain_in = 1'b0;
      ain = 16'h0000;
      repeat (10) @(posedge clk_sys);
      #2 rst_b = 1'b1;
      repeat (4) @(posedge clk_sys);
      #2 cs_n = 1'b0;
      for (k = 0; k < 4; k++)
      begin
         conv;
         chk(bw > 0 && bw <= 50, "parallel busy width");
         chk(tsar > 0 && tbf > tsar, "busy low before conversion end");
         chk(tdv > 0 && tdv <= 50, "parallel data late");
         chk(tbf - tdv >= 2, "data valid too close to busy low");
         chk(par_data_o === exp_q.pop_front() && par_data_oe === 1'b1, "parallel word");
      end
      $display("test parallel done");
      interface_select = 1'b1;
      for (d = 0; d < 4; d++)
      begin
         serial_clock_divider = 2'(d);
         conv;
         chk(srt_host_model_i.word === exp_q.pop_front(), "master word");
         chk(srt_host_model_i.per * 25 >= min_ns[d], "clock period short");
         chk(srt_host_model_i.per == (typ_ns[d] + 24) / 25, "clock period");
         chk(bw * 25 <= bsy_ns[d], "serial busy width");
         chk(srt_host_model_i.lead * 25 >= (d == 0 ? 3 : 17), "marker to first edge");
         chk(srt_host_model_i.trail * 25 >= trl_ns[d], "last edge to marker end");
         chk(tfs > tsar && tfs <= 50, "marker after conversion");
         chk(srt_host_model_i.bdrop >= 1 && srt_host_model_i.bdrop <= 2, "busy drop");
      end
      $display("test master after done");
      read_during_conv = 1'b1;
      conv;
      chk(tfs >= 19 && tfs <= 23, "marker during conversion");
      chk(bw > 0 && bw <= 50, "busy width during mode");
      chk(srt_host_model_i.word === exp_q.pop_front(), "during word");
      $display("test master during done");
      read_during_conv = 1'b0;
      serial_clock_divider = 2'b11;
      convert_strobe_n = 1'b0;
      repeat (2) @(posedge clk_sys);
      #2 convert_strobe_n = 1'b1;
      repeat (40) @(posedge clk_sys);
      #2;
      chk(master_oe === 1'b1 && frame_sync_o === 1'b1, "master outputs driven");
      cs_n = 1'b1;
      repeat (4) @(posedge clk_sys);
      #2;
      chk(master_oe === 1'b0 && serial_result_oe === 1'b0 && frame_sync_o === 1'b0, "release");
      rst_b = 1'b0;
      #5;
      chk(busy === 1'b0 && par_data_oe === 1'b0 && master_oe === 1'b0, "reset state");
      exp_q.delete();
      repeat (3) @(posedge clk_sys);
      #2 rst_b = 1'b1;
      repeat (4) @(posedge clk_sys);
      #2;
      $display("test abort and reset done");
      slave_mode = 1'b1;
      conv;
      chk(bw > 0 && bw <= 50, "first buffered busy");
      conv;
      chk(bw > 0 && bw <= 50, "second buffered busy");
      conv;
      chk(bw > 0 && bw <= 50, "stalled busy too long");
      chk(par_data_oe === 1'b0, "parallel port on in serial");
      for (k = 0; k < 3; k++)
      begin
         cs_n = 1'b0;
         repeat (8) @(posedge clk_sys);
         #2;
         srt_host_model_i.slave_read(w);
         chk(w === exp_q.pop_front(), "slave word");
         cs_n = 1'b1;
         repeat (8) @(posedge clk_sys);
         #2;
         chk(serial_result_oe === 1'b0, "slave release");
      end
      chk(busy === 1'b0, "busy stuck after drain");
      $display("test slave buffer done");
      print_verdict;
   end
endmodule // srt_adc_ctrl_tb_top

// File: testbench/srt_host_model.sv
// Purpose: host side of the readout port, serial master receiver and slave clock source
// Assumes: marker and clock lines have board pull-downs while released
// Notes: clock period, lead, trail and busy drop are measured in clk_sys cycles
`timescale 1ns/1ps
module srt_host_model
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // device outputs
   input wire logic busy,
   input wire logic frame_sync_o,
   input wire logic serial_clk_o,
   input wire logic master_oe,
   input wire logic serial_result_out,
   input wire logic serial_result_oe,
   // host clock for slave reads
   output logic host_sclk
);
   logic sdo_last = 1'b0;
   logic fs_q = 1'b0;
   logic sck_q = 1'b0;
   logic busy_q = 1'b0;
   logic [15:0] sh = 16'h0000;
   logic [15:0] word = 16'h0000;
   int cyc = 0;
   int bits, t_sync, t_rise, t_fall, t_sdrop, per, lead, trail, bdrop;
   wire fs_w = master_oe & frame_sync_o;
   wire sck_w = master_oe & serial_clk_o;
   // a released data line shows the inverse of its last level, so a stale bit never matches
   wire sdo_w = serial_result_oe ? serial_result_out : ~sdo_last;

   initial host_sclk = 1'b0;

   always @(posedge clk_sys)
   begin
      cyc++;
      fs_q <= fs_w;
      sck_q <= sck_w;
      busy_q <= busy;
      if (serial_result_oe)
         sdo_last <= serial_result_out;
      if (fs_w && !fs_q)
      begin
         bits = 0;
         t_sync = cyc;
      end
      if (sck_w && !sck_q && fs_w)
      begin
         if (bits == 0)
            lead = cyc - t_sync;
         else
            per = cyc - t_rise;
         t_rise = cyc;
         sh = {sh[14:0], sdo_w};
         bits++;
      end
      if (!sck_w && sck_q)
         t_fall = cyc;
      if (!fs_w && fs_q)
      begin
         trail = cyc - t_fall;
         t_sdrop = cyc;
         word = sh;
      end
      if (!busy && busy_q)
         bdrop = cyc - t_sdrop;
   end

   // slow host clock: the pin synchroniser needs several cycles per level
   task automatic slave_read(output logic [15:0] w);
      int i;
      for (i = 0; i < 16; i++)
      begin
         w = {w[14:0], sdo_w};
         @(posedge clk_sys) #2 host_sclk = 1'b1;
         repeat (4) @(posedge clk_sys);
         #2 host_sclk = 1'b0;
         repeat (6) @(posedge clk_sys);
         #2;
      end
   endtask
endmodule // srt_host_model
